// *** rtl/i2c_register_port.sv ***
// Two-wire slave port and register bank of the video digitizer.
// Assumes SCL far slower than ref_clk; status bytes come from logic on ref_clk.
`timescale 1ns/1ps
module i2c_register_port
  import digitizer_i2c_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  input  wire logic                   slave_addr_strap_pin,
  input  wire logic [NUM_RO*8-1:0]    status_data,
  output logic                        sda_out,
  output logic                        sda_oe,
  output logic      [NUM_RW*8-1:0]    reg_data
);

  typedef struct packed {
    link_state_type         state;
    byte_kind_type          kind;
    logic [2:0]             bit_cnt;
    logic [7:0]             shreg;
    logic [7:0]             ptr;
    logic                   done;
    logic                   rd_mode;
    logic                   mack_ok;
    logic                   scl_q;
    logic                   sda_q;
    logic                   sda_oe;
    logic [NUM_RW-1:0][7:0] regs;
  } port_state_type;

  port_state_type         state_ff;
  port_state_type         nxt_state;
  logic [1:0]             rst_sync_ff;
  logic                   rst_n;
  logic [2:0]             pins;
  logic                   scl;
  logic                   sda;
  logic                   strap;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_seen;
  logic                   stop_seen;
  logic [NUM_RO-1:0][7:0] status_bytes;
  logic [7:0]             next_byte;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  ({scl_in, sda_in, slave_addr_strap_pin}),
    .pin_out (pins)
  );

  assign scl          = pins[2];
  assign sda          = pins[1];
  assign strap        = pins[0];
  assign status_bytes = status_data;
  assign scl_rise     = scl & ~state_ff.scl_q;
  assign scl_fall     = ~scl & state_ff.scl_q;
  assign start_seen   = scl & state_ff.scl_q & state_ff.sda_q & ~sda;
  assign stop_seen    = scl & state_ff.scl_q & ~state_ff.sda_q & sda;

  // Byte served at a subaddress; holes and undefined bits give zero
  function automatic logic [7:0] read_byte(input logic [7:0] addr,
                                           input logic [NUM_RW-1:0][7:0] regs,
                                           input logic [NUM_RO-1:0][7:0] stat);
    logic [7:0] ro_idx;
    ro_idx = addr - RO_BASE;
    if (addr < RO_BASE) begin
      read_byte = regs[addr[3:0]] & RW_MASK[addr[3:0]];
    end else if (addr <= RO_END) begin
      read_byte = stat[ro_idx[3:0]] & RO_MASK[ro_idx[3:0]];
    end else begin
      read_byte = 8'h00;
    end
  endfunction : read_byte

  // One decode feeds both load points; MSB picked by index, not by shift
  assign next_byte = read_byte(state_ff.ptr, state_ff.regs, status_bytes);

  always_comb begin
    nxt_state       = state_ff;
    nxt_state.scl_q = scl;
    nxt_state.sda_q = sda;
    if (stop_seen) begin
      nxt_state.state  = ST_IDLE;
      nxt_state.sda_oe = 1'b0;
    end else if (start_seen) begin
      // Repeated START restarts address reception
      nxt_state.state   = ST_RX;
      nxt_state.kind    = KIND_ADDR;
      nxt_state.bit_cnt = 3'h0;
      nxt_state.done    = 1'b0;
      nxt_state.rd_mode = 1'b0;
      nxt_state.sda_oe  = 1'b0;
    end else begin
      unique case (state_ff.state)
        ST_IDLE: begin
          nxt_state.sda_oe = 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            nxt_state.shreg   = {state_ff.shreg[6:0], sda};
            nxt_state.bit_cnt = state_ff.bit_cnt + 3'h1;
            nxt_state.done    = (state_ff.bit_cnt == 3'h7);
          end else if (scl_fall && state_ff.done) begin
            nxt_state.done  = 1'b0;
            nxt_state.state = ST_ACK;
            nxt_state.sda_oe = 1'b1;
            unique case (state_ff.kind)
              KIND_ADDR: begin
                if (state_ff.shreg[7:1] == {SLAVE_ADDR_HIGH, strap}) begin
                  nxt_state.rd_mode = state_ff.shreg[0];
                  nxt_state.kind    = KIND_SUB;
                end else begin
                  nxt_state.state  = ST_IDLE;
                  nxt_state.sda_oe = 1'b0;
                end
              end
              KIND_SUB: begin
                nxt_state.ptr  = state_ff.shreg;
                nxt_state.kind = KIND_DATA;
              end
              default: begin
                if (state_ff.ptr < RO_BASE) begin
                  nxt_state.regs[state_ff.ptr[3:0]] = state_ff.shreg & RW_MASK[state_ff.ptr[3:0]];
                end
                nxt_state.ptr = state_ff.ptr + 8'h01;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt_state.bit_cnt = 3'h0;
            if (state_ff.rd_mode) begin
              nxt_state.state  = ST_TX;
              nxt_state.shreg  = next_byte;
              nxt_state.sda_oe = ~next_byte[7];
              nxt_state.ptr    = state_ff.ptr + 8'h01;
            end else begin
              nxt_state.state  = ST_RX;
              nxt_state.sda_oe = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (state_ff.bit_cnt == 3'h7) begin
              nxt_state.state  = ST_MACK;
              nxt_state.sda_oe = 1'b0;
            end else begin
              nxt_state.shreg   = {state_ff.shreg[6:0], 1'b0};
              nxt_state.sda_oe  = ~state_ff.shreg[6];
              nxt_state.bit_cnt = state_ff.bit_cnt + 3'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            nxt_state.mack_ok = ~sda;
          end else if (scl_fall) begin
            nxt_state.bit_cnt = 3'h0;
            if (state_ff.mack_ok) begin
              nxt_state.state  = ST_TX;
              nxt_state.shreg  = next_byte;
              nxt_state.sda_oe = ~next_byte[7];
              nxt_state.ptr    = state_ff.ptr + 8'h01;
            end else begin
              nxt_state.state  = ST_IDLE;
              nxt_state.sda_oe = 1'b0;
            end
          end
        end
        default: begin
          nxt_state.state  = ST_IDLE;
          nxt_state.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff         <= '0;
      state_ff.state   <= ST_IDLE;
      state_ff.kind    <= KIND_ADDR;
      state_ff.scl_q   <= 1'b1;
      state_ff.sda_q   <= 1'b1;
      state_ff.regs    <= RW_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out  = SDA_DRIVE_LOW;
  assign sda_oe   = state_ff.sda_oe;
  assign reg_data = state_ff.regs;

endmodule : i2c_register_port

// *** shared/digitizer_i2c_pkg.sv ***
// Constants, register layout and state types of the digitizer's two-wire register port.
// Assumes one 20 MHz clock domain; the register bank sits inside the port module.
// Operation
// - Port is a two-wire slave that takes register writes and serves register reads.
// - Writes and reads use two distinct slave addresses.
// - Address bit 1 follows the address strap pin.
// - Strap low gives 0x40/0x41, strap high gives 0x42/0x43.
// - Register pointer advances by one after every data byte.
// - Read-write registers store and return data; read-only ones ignore writes.
// - Read data flows from the set subaddress; bus released on master not-ack.
// - Undefined register bits ignore writes and read as zero.
package digitizer_i2c_pkg;

  localparam int         NUM_RW          = 16;
  localparam int         NUM_RO          = 10;
  localparam logic [7:0] RO_BASE         = 8'h10;
  localparam logic [7:0] RO_END          = 8'h19;
  // Upper six bits of the slave address; bit 1 comes from the strap
  localparam logic [5:0] SLAVE_ADDR_HIGH = 6'h10;
  localparam logic       SDA_DRIVE_LOW   = 1'b0;

  // Writable bits of each read-write register
  localparam logic [NUM_RW-1:0][7:0] RW_MASK = {
    8'h3F, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h3F, 8'h1F, 8'h03,
    8'h07, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF};

  // Defined bits of each read-only status register
  localparam logic [NUM_RO-1:0][7:0] RO_MASK = {
    8'h01, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'hFF};

  localparam logic [NUM_RW-1:0][7:0] RW_RESET = '0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_MACK = 3'b100
  } link_state_type;

  typedef enum logic [1:0] {
    KIND_ADDR = 2'b00,
    KIND_SUB  = 2'b01,
    KIND_DATA = 2'b10
  } byte_kind_type;

endpackage : digitizer_i2c_pkg

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are plain levels; only the second stage may be read.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_type;

  sync_state_type state_ff;
  sync_state_type nxt_state;

  always_comb begin
    nxt_state.stage1 = pin_in;
    nxt_state.stage2 = state_ff.stage1;
  end

  // Idle bus levels are high, so reset to high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pin_out = state_ff.stage2;

endmodule : pin_sync

// *** verif/i2c_register_port_properties.sv ***
// Concurrent checks on the pins and register outputs of the register port.
// Assumes SCL far slower than ref_clk and a pull-up on SDA.
`timescale 1ns/1ps
module i2c_register_port_properties
  import digitizer_i2c_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                reset_n,
  input wire logic                scl_in,
  input wire logic                sda_in,
  input wire logic                sda_out,
  input wire logic                sda_oe,
  input wire logic [NUM_RW*8-1:0] reg_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("sda_out driven high");
  AST_UNDEF_ZERO: assert property ((reg_data & ~RW_MASK) == '0)
    else $error("undefined register bit set");
  // Sync lag lets a change land just after the rise
  AST_REG_SCL_LOW: assert property ($changed(reg_data) |-> !scl_in || !$past(scl_in, 2))
    else $error("register changed while SCL high");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in || !$past(scl_in, 2))
    else $error("SDA drive changed while SCL high");
  AST_OE_HOLD: assert property ($rose(sda_oe) |=> sda_oe [*5])
    else $error("SDA drive too short");
  AST_START_FREE: assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> !sda_oe)
    else $error("device pulling SDA at START");
  AST_IDLE_RELEASE: assert property (scl_in [*8] |-> !sda_oe)
    else $error("SDA held while bus idle");
  AST_IDLE_QUIET: assert property (scl_in [*8] |=> $stable(reg_data))
    else $error("register changed while bus idle");

  CV_ACK: cover property ($rose(sda_oe));
  CV_WRITE: cover property ($changed(reg_data));
  CV_STOP: cover property (scl_in && $past(scl_in) && $rose(sda_in));
endmodule : i2c_register_port_properties

bind i2c_register_port i2c_register_port_properties i_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .reg_data(reg_data));

// *** verif/i2c_master_model.sv ***
// Bus master model for the two-wire link, called from the bench.
// Assumes a pull-up on SDA; sda_pull high pulls the line low.
`timescale 1ns/1ps
module i2c_master_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // bit time scaled
  // Bench rate far above the bus limits; ref_clk stands in for the oscillator
  localparam time QTR = 100ns;

  // SCL stands high between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic start();
    sda_pull = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b1;
    #QTR scl = 1'b0;
    #QTR;
  endtask : start

  // Data moves only while SCL is low
  task automatic bit_io(input logic b, output logic v);
    sda_pull = ~b;
    #QTR scl = 1'b1;
    #QTR v = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask : bit_io

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], v);
    end
    bit_io(1'b1, ack);
  endtask : wbyte

  // ack each byte, not-ack the last
  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(nak, v);
  endtask : rbyte

  task automatic stop();
    sda_pull = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b0;
    #(2 * QTR);
  endtask : stop
endmodule : i2c_master_model

// *** verif/tb_top.sv ***
// Self-checking bench for the register port against a register model.
// Assumes the master model's timing is aligned to ref_clk by the caller.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_top
  import digitizer_i2c_pkg::*;
;
  logic                     ref_clk;
  logic                     reset_n;
  logic                     strap;
  logic [NUM_RO-1:0][7:0]   st;
  logic                     sda_out;
  logic                     sda_oe;
  logic [NUM_RW*8-1:0]      reg_data;
  wire                      scl;
  wire                      sda_pull;
  wire                      sda;
  int                       err_count;
  int                       n_checks;
  logic [7:0]               rw[NUM_RW];

  // Pull-up: line low when either party pulls
  assign sda = ~(sda_pull | sda_oe);

  i2c_register_port i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .slave_addr_strap_pin(strap), .status_data(st), .sda_out(sda_out),
    .sda_oe(sda_oe), .reg_data(reg_data));
  i2c_master_model i_master (.scl(scl), .sda_pull(sda_pull), .sda(sda));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic xfer(input logic [7:0] b, input logic exp);
    logic a;
    i_master.wbyte(b, a);
    `CHK(a, exp)
  endtask : xfer

  task automatic chk_regs();
    for (int k = 0; k < NUM_RW; k++) `CHK(reg_data[8*k+:8], rw[k])
  endtask : chk_regs

  // Status bytes keep defined bits only; reserved reads zero
  function automatic logic [7:0] exp_rd(input int p);
    if (p < NUM_RW) return rw[p];
    if (p < NUM_RW + NUM_RO) return st[p-NUM_RW] & RO_MASK[p-NUM_RW];
    return 8'h00;
  endfunction : exp_rd

  initial begin
    #1_000_000;
    err_count++;
    complete_run();
  end

  initial begin
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] sub;
    int         p;
    err_count = 0;
    n_checks = 0;
    reset_n = 1'b0;
    strap = 1'b0;
    st = '0;
    void'($urandom(56772));
    for (int k = 0; k < NUM_RW; k++) rw[k] = 8'h00;
    repeat (16) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    for (int s = 0; s < 2; s++) begin
      if (s == 1) begin
        // Mid-run reset must clear the bank
        reset_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        for (int k = 0; k < NUM_RW; k++) rw[k] = 8'h00;
        repeat (6) @(posedge ref_clk);
      end
      @(posedge ref_clk);
      #1 strap = s[0];
      for (int k = 0; k < NUM_RO; k++) st[k] = 8'($urandom);
      chk_regs();
      a = 8'h40 | 8'(2 * s);
      i_master.start();
      xfer(a ^ 8'h02, 1'b1);
      i_master.stop();
      i_master.start();
      xfer(a ^ 8'h03, 1'b1);
      i_master.stop();
      i_master.start();
      xfer(a, 1'b0);
      xfer(8'h0E, 1'b0);
      for (p = 8'h0E; p < 8'h12; p++) begin
        d = 8'($urandom);
        xfer(d, 1'b0);
        if (p < NUM_RW) rw[p] = d & RW_MASK[p];
      end
      i_master.stop();
      chk_regs();
      for (int j = 0; j < 2; j++) begin
        sub = j ? 8'h18 : 8'h0E;
        i_master.start();
        xfer(a, 1'b0);
        xfer(sub, 1'b0);
        i_master.stop();
        i_master.start();
        xfer(a | 8'h01, 1'b0);
        for (p = sub; p < sub + 3; p++) begin
          i_master.rbyte(p == sub + 2, d);
          `CHK(d, exp_rd(p))
        end
        i_master.stop();
        `CHK(sda_oe, 1'b0)
      end
    end
    complete_run();
  end
endmodule : tb_top
